// file: verilog/wbs_slave_port.v
// Purpose: 32-bit expansion bus slave with burst DMA access to packet data
// Assumes: All bus pins are asynchronous to clk and pass two flip-flops
// Notes: Burst clock is sampled, not used as a clock; store holds 16 words
// Behaviour
// - Byte-lane enables pick the data lanes: doubleword, low word, high word or one byte.
// - On I/O writes only enabled lanes change the packet store; burst writes change all four lanes.
// - The upper two enables select the word, the low word-address bit plays no part.
// - Local decode is driven both ways and is low on a window match with qualifier low.
// - Compressed cycles with half-clock strobes are accepted.
// - Burst data movement is timed by the burst clock.
// - Data-path select gives slave DMA direct access to the packet data.
// - Transfer direction high writes into the device, low reads from it.
// - The DMA write cycle input low marks slave DMA write transfers.
// - Ready is sampled and a transfer happens at the next burst clock edge only if ready.
// - Bursts run at up to one doubleword per burst clock.
// - Byte-lane enables are caught on the address strobe rising edge.
// - The I/O address is caught on the address strobe trailing edge.
`include "wbs_consts.vh"

module wbs_slave_port (
    input wire clk,
    input wire reset,
    input wire [11:0] ioWindowBase,
    input wire [15:2] ioAddress,
    input wire io_space_qualifier,
    input wire address_strobe_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire [3:0] byte_lane_enable_n,
    input wire [31:0] busDataIn,
    output reg [31:0] busDataOut,
    output reg [3:0] busDataOe_n,
    output reg local_decode_n,
    input wire burst_clock,
    input wire data_path_select_n,
    input wire transfer_direction,
    input wire dma_write_cycle_n,
    input wire ready_return_n,
    output reg [3:0] packetPointer,
    output reg burstActive
);
    // Lane mask for an enable pattern, zero if unsupported
    function [3:0] laneMask;
        input [3:0] beN;
        begin
            case (beN)
                `WBS_BE_DWORD, `WBS_BE_LOW, `WBS_BE_HIGH,
                `WBS_BE_B0, `WBS_BE_B1, `WBS_BE_B2, `WBS_BE_B3: laneMask = ~beN;
                default: laneMask = 4'h0;
            endcase
        end
    endfunction

    // Two-stage capture of every pin input
    reg [`WBS_SYNC_W-1:0] syncA;
    reg [`WBS_SYNC_W-1:0] syncB;
    wire [`WBS_SYNC_W-1:0] pinVec;

    assign pinVec = {ioAddress, io_space_qualifier, address_strobe_n, read_strobe_n,
        write_strobe_n, byte_lane_enable_n, busDataIn, burst_clock, data_path_select_n,
        transfer_direction, dma_write_cycle_n, ready_return_n};

    always @(posedge clk) begin
        if (reset) begin
            syncA <= {`WBS_SYNC_W{1'b1}};
            syncB <= {`WBS_SYNC_W{1'b1}};
        end else begin
            syncA <= pinVec;
            syncB <= syncA;
        end
    end

    wire [13:0] sAddr;
    wire sAen;
    wire sAds;
    wire sRd;
    wire sWr;
    wire [3:0] sBe;
    wire [31:0] sData;
    wire sBclk;
    wire sSel;
    wire sDir;
    wire sCyc;
    wire sRdy;

    assign {sAddr, sAen, sAds, sRd, sWr, sBe, sData, sBclk, sSel, sDir, sCyc, sRdy} = syncB;

    // Previous values for edge finding
    reg prevAds;
    reg prevRd;
    reg prevWr;
    reg prevBclk;
    wire adsRise;
    wire rdFall;
    wire rdRise;
    wire wrRise;
    wire bclkRise;

    assign adsRise = sAds && !prevAds;
    assign rdFall = !sRd && prevRd;
    assign rdRise = sRd && !prevRd;
    assign wrRise = sWr && !prevWr;
    assign bclkRise = sBclk && !prevBclk;

    // Access state caught at the address strobe
    reg [13:0] latAddr;
    reg [3:0] latLanes;
    reg latAen;
    wire aenNow;
    wire winHit;
    wire dataHit;

    always @(posedge clk) begin
        if (reset) begin
            prevAds <= 1'b1;
            prevRd <= 1'b1;
            prevWr <= 1'b1;
            // Matches the synchroniser reset level, so no false edge after reset
            prevBclk <= 1'b1;
            latAddr <= 14'h0;
            latLanes <= 4'h0;
            latAen <= 1'b1;
        end else begin
            prevAds <= sAds;
            prevRd <= sRd;
            prevWr <= sWr;
            prevBclk <= sBclk;
            if (adsRise) begin
                latAddr <= sAddr;
                latLanes <= laneMask(sBe);
                latAen <= sAen;
            end
        end
    end

    // Qualifier is transparent while the strobe is low
    assign aenNow = sAds ? latAen : sAen;
    assign winHit = (sAddr[13:2] == ioWindowBase) && !aenNow;
    assign dataHit = (latAddr[13:2] == ioWindowBase) && !latAen
        && (latAddr[1:0] == `WBS_DATA_OFS);

    always @(posedge clk) begin
        if (reset) begin
            local_decode_n <= 1'b1;
        end else begin
            local_decode_n <= !winHit;
        end
    end

    // Burst side state
    reg readyArmed;
    wire selActive;
    wire dmaEdge;
    wire dmaWrXfer;
    wire dmaRdXfer;
    wire bufInReady;
    wire bufOutValid;
    wire bufOutReady;
    wire [31:0] bufOutData;

    assign selActive = !sSel;
    // Transfer on this edge only if ready was seen on the previous one
    assign dmaEdge = bclkRise && selActive && readyArmed;
    assign dmaWrXfer = dmaEdge && sDir && !sCyc && bufInReady;
    assign dmaRdXfer = dmaEdge && !sDir;

    always @(posedge clk) begin
        if (reset) begin
            readyArmed <= 1'b0;
            burstActive <= 1'b0;
        end else begin
            burstActive <= selActive;
            if (!selActive) begin
                readyArmed <= 1'b0;
            end else if (bclkRise) begin
                readyArmed <= !sRdy;
            end
        end
    end

    // I/O write held until the store port takes it
    reg ioWrPend;
    reg [3:0] ioWrLanes;
    reg [31:0] ioWrData;
    reg ioRdActive;

    always @(posedge clk) begin
        if (reset) begin
            ioWrPend <= 1'b0;
            ioWrLanes <= 4'h0;
            ioWrData <= 32'h0;
            ioRdActive <= 1'b0;
        end else begin
            // Trailing edge only, so half-clock strobes are caught as well
            if (wrRise && dataHit && (latLanes != 4'h0)) begin
                ioWrPend <= 1'b1;
                ioWrLanes <= latLanes;
                ioWrData <= sData;
            end else begin
                ioWrPend <= 1'b0;
            end
            if (rdFall && dataHit && (latLanes != 4'h0)) begin
                ioRdActive <= 1'b1;
            end else if (sRd) begin
                ioRdActive <= 1'b0;
            end
        end
    end

    // Store port: I/O write first, then buffered burst words, else read
    reg ramWrEn;
    reg [3:0] ramLanes;
    reg [31:0] ramWrData;
    wire [31:0] ramRdData;

    assign bufOutReady = !ioWrPend && selActive;

    always @* begin
        ramWrEn = 1'b0;
        ramLanes = 4'h0;
        ramWrData = ioWrData;
        if (ioWrPend) begin
            ramWrEn = 1'b1;
            ramLanes = ioWrLanes;
        end else if (bufOutValid && bufOutReady) begin
            ramWrEn = 1'b1;
            ramLanes = 4'hf;
            ramWrData = bufOutData;
        end
    end

    wbs_skid_buf burstBuf (
        .clk(clk),
        .reset(reset),
        .inValid(dmaWrXfer),
        .inReady(bufInReady),
        .inData(sData),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outData(bufOutData)
    );

    wbs_pkt_ram store (
        .clk(clk),
        .wrEn(ramWrEn),
        .wrLanes(ramLanes),
        .addr(packetPointer),
        .wrData(ramWrData),
        .rdData(ramRdData)
    );

    // Pointer moves once a doubleword is finished
    wire ioWordDone;
    wire ptrStep;
    reg [3:0] next_packetPointer;

    assign ioWordDone = (ioWrPend && ioWrLanes[3])
        || (rdRise && ioRdActive && latLanes[3]);
    assign ptrStep = ioWordDone || (bufOutValid && bufOutReady && !ioWrPend) || dmaRdXfer;

    always @* begin
        next_packetPointer = packetPointer;
        if (ptrStep) begin
            next_packetPointer = packetPointer + 4'h1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            packetPointer <= `WBS_PTR_RESET;
        end else begin
            packetPointer <= next_packetPointer;
        end
    end

    // Data pins: I/O read drives enabled lanes, burst read drives all
    always @(posedge clk) begin
        if (reset) begin
            busDataOut <= 32'h0;
            busDataOe_n <= 4'hf;
        end else begin
            if (selActive && !sDir) begin
                busDataOe_n <= 4'h0;
                if (dmaRdXfer) begin
                    busDataOut <= ramRdData;
                end
            end else if (ioRdActive && !sRd) begin
                busDataOe_n <= ~latLanes;
                busDataOut <= ramRdData;
            end else begin
                busDataOe_n <= 4'hf;
            end
        end
    end
endmodule // wbs_slave_port

// file: pkg/wbs_consts.vh
// Purpose: Shared constants of the wide bus slave and burst DMA port
// Assumes: Included by bare name from every design file that needs it
// Notes: Offsets are doubleword offsets within the 16-byte I/O window
`ifndef WBS_CONSTS_VH
`define WBS_CONSTS_VH

`define WBS_DATA_W 32
`define WBS_LANES 4
`define WBS_PTR_W 4
`define WBS_DEPTH 16
`define WBS_WIN_W 12
`define WBS_DATA_OFS 2'h2
`define WBS_PTR_RESET 4'h0
`define WBS_BE_DWORD 4'h0
`define WBS_BE_LOW 4'hc
`define WBS_BE_HIGH 4'h3
`define WBS_BE_B0 4'he
`define WBS_BE_B1 4'hd
`define WBS_BE_B2 4'hb
`define WBS_BE_B3 4'h7
`define WBS_SYNC_W 59

`endif

// file: verilog/wbs_pkt_ram.v
// Purpose: Packet data store with per-lane writes
// Assumes: Single port, one access per clock
// Notes: Read data is registered, valid one cycle after the address
`include "wbs_consts.vh"

module wbs_pkt_ram (
    input wire clk,
    input wire wrEn,
    input wire [3:0] wrLanes,
    input wire [3:0] addr,
    input wire [31:0] wrData,
    output reg [31:0] rdData
);
    reg [31:0] mem [0:`WBS_DEPTH-1];
    integer i;

    always @(posedge clk) begin
        if (wrEn) begin
            for (i = 0; i < `WBS_LANES; i = i + 1) begin
                // Disabled lanes keep their old byte
                if (wrLanes[i]) begin
                    mem[addr][i*8 +: 8] <= wrData[i*8 +: 8];
                end
            end
        end
        rdData <= mem[addr];
    end
endmodule // wbs_pkt_ram

// file: verilog/wbs_skid_buf.v
// Purpose: Two-entry buffer between burst capture and packet store
// Assumes: Same clock on both sides
// Notes: Output data comes straight from the head register
`include "wbs_consts.vh"

module wbs_skid_buf (
    input wire clk,
    input wire reset,
    input wire inValid,
    output wire inReady,
    input wire [31:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [31:0] outData
);
    reg [31:0] head;
    reg [31:0] tail;
    reg [1:0] count;
    wire push;
    wire pop;

    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData = head;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge clk) begin
        if (reset) begin
            count <= 2'h0;
            head <= 32'h0;
            tail <= 32'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) begin
                        head <= inData;
                    end else begin
                        tail <= inData;
                    end
                    count <= count + 2'h1;
                end
                2'b01: begin
                    head <= tail;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    if (count == 2'h1) begin
                        head <= inData;
                    end else begin
                        head <= tail;
                        tail <= inData;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // wbs_skid_buf

// file: test/wbs_slave_port_props.sv
// Purpose: Port checks for the wide bus slave
// Assumes: Bound to wbs_slave_port, one clock domain
// Notes: Pins see two sync stages plus one output register
module wbs_slave_port_props (
    input wire clk,
    input wire reset,
    input wire io_space_qualifier,
    input wire address_strobe_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire [3:0] busDataOe_n,
    input wire local_decode_n,
    input wire data_path_select_n,
    input wire transfer_direction,
    input wire [3:0] packetPointer,
    input wire burstActive
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_reset_idle_out: assert property (disable iff (1'b0) reset |=> busDataOe_n == 4'hf
        && local_decode_n && packetPointer == 4'h0 && !burstActive)
        else $error("outputs not idle after reset");
    a_select_idle: assert property (data_path_select_n [*5] |-> !burstActive)
        else $error("burst flag without select");
    a_select_seen: assert property ((!data_path_select_n) [*5] |-> burstActive)
        else $error("select not seen");
    a_lanes_legal: assert property (busDataOe_n inside {4'hf, 4'h0, 4'hc, 4'h3, 4'he,
        4'hd, 4'hb, 4'h7}) else $error("lane drive pattern unsupported");
    a_io_release: assert property ((read_strobe_n && data_path_select_n) [*6]
        |-> busDataOe_n == 4'hf) else $error("lanes driven without read");
    a_dma_read_drive: assert property ((!data_path_select_n && !transfer_direction) [*5]
        |-> busDataOe_n == 4'h0) else $error("dma read lanes not driven");
    a_dma_write_float: assert property ((!data_path_select_n && transfer_direction
        && read_strobe_n) [*6] |-> busDataOe_n == 4'hf) else $error("lanes driven on dma write");
    a_pointer_step: assert property (packetPointer != $past(packetPointer)
        |-> packetPointer == $past(packetPointer) + 4'h1) else $error("pointer jumped");
    a_pointer_hold: assert property ((data_path_select_n && read_strobe_n
        && write_strobe_n) [*8] |-> $stable(packetPointer)) else $error("pointer moved idle");
    a_decode_off: assert property ((io_space_qualifier && !address_strobe_n) [*7]
        |-> local_decode_n) else $error("decode with qualifier high");
endmodule // wbs_slave_port_props

bind wbs_slave_port wbs_slave_port_props u_wbs_slave_port_props (.clk(clk), .reset(reset),
    .io_space_qualifier(io_space_qualifier), .address_strobe_n(address_strobe_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .busDataOe_n(busDataOe_n), .local_decode_n(local_decode_n),
    .data_path_select_n(data_path_select_n), .transfer_direction(transfer_direction),
    .packetPointer(packetPointer), .burstActive(burstActive));

// file: test/wbs_dma_ctrl.sv
// Purpose: Bus DMA controller model for burst transfers
// Assumes: Burst clock runs only inside a burst
// Notes: Read words are queued in seen for the bench
module wbs_dma_ctrl (
    output reg burst_clock,
    output reg data_path_select_n,
    output reg transfer_direction,
    output reg dma_write_cycle_n,
    output reg ready_return_n,
    output reg [31:0] dmaData,
    input wire [31:0] busDataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] seen [$];
    initial begin
        burst_clock = 1'b0;
        data_path_select_n = 1'b1;
        transfer_direction = 1'b0;
        dma_write_cycle_n = 1'b1;
        ready_return_n = 1'b1;
        dmaData = 32'h0;
    end
    function automatic logic [31:0] pat(input int i);
        return {8'h5a, i[7:0], 8'hc3, ~i[7:0]};
    endfunction
    // Ready high on every third rise when stalling
    task automatic burst(input logic wr, input int n, input logic stall);
        int i;
        int k;
        logic armed;
        logic moved;
        // Keep pin changes off the sampling clock edges
        #0.3;
        i = 0;
        k = 0;
        armed = 1'b0;
        transfer_direction = wr;
        dma_write_cycle_n = !wr;
        data_path_select_n = 1'b0;
        while (i < n) begin
            dmaData = pat(i);
            ready_return_n = stall && (k % 3 == 2);
            #62.5 burst_clock = 1'b1;
            moved = armed;
            armed = !ready_return_n;
            k++;
            #62.5 burst_clock = 1'b0;
            if (moved) begin
                if (!wr) seen.push_back(busDataOut);
                i++;
            end
        end
        ready_return_n = 1'b1;
        #62.5 data_path_select_n = 1'b1;
        dmaData = ~dmaData;
    endtask
endmodule // wbs_dma_ctrl

// file: test/tb_wbs_slave_port.sv
// Purpose: Self-checking bench for the wide bus slave
// Assumes: DMA side modelled by wbs_dma_ctrl
// Notes: Store contents tracked in mem
`include "wbs_consts.vh"
module tb_wbs_slave_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] BASE = 12'h030;
    localparam logic [15:2] DA = {BASE, `WBS_DATA_OFS};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:2] ioAddress = 14'h0;
    logic io_space_qualifier = 1'b1;
    logic address_strobe_n = 1'b1;
    logic read_strobe_n = 1'b1;
    logic write_strobe_n = 1'b1;
    logic [3:0] byte_lane_enable_n = 4'hf;
    logic [31:0] ioData = 32'h0;
    logic [31:0] busDataOut, dmaData, rdData;
    logic [31:0] mem [16];
    logic [3:0] busDataOe_n, packetPointer, rdOe;
    logic local_decode_n, burstActive, burst_clock, data_path_select_n, transfer_direction;
    logic dma_write_cycle_n, ready_return_n, rdDec;
    logic no_wait_request_n = 1'b1;
    // External no-wait logic: follows decode, dropped once the start strobe rises
    always @(posedge clk) no_wait_request_n <= address_strobe_n ? 1'b1 : local_decode_n;
    int miscompares = 0;
    int compares = 0;
    always #4 clk = ~clk;
    wbs_slave_port u_wbs_slave_port (.clk(clk), .reset(reset), .ioWindowBase(BASE),
        .ioAddress(ioAddress), .io_space_qualifier(io_space_qualifier),
        .address_strobe_n(address_strobe_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .byte_lane_enable_n(byte_lane_enable_n),
        .busDataIn(data_path_select_n ? ioData : dmaData), .busDataOut(busDataOut),
        .busDataOe_n(busDataOe_n), .local_decode_n(local_decode_n), .burst_clock(burst_clock),
        .data_path_select_n(data_path_select_n), .transfer_direction(transfer_direction),
        .dma_write_cycle_n(dma_write_cycle_n), .ready_return_n(ready_return_n),
        .packetPointer(packetPointer), .burstActive(burstActive));
    wbs_dma_ctrl u_wbs_dma_ctrl (.burst_clock(burst_clock),
        .data_path_select_n(data_path_select_n), .transfer_direction(transfer_direction),
        .dma_write_cycle_n(dma_write_cycle_n), .ready_return_n(ready_return_n),
        .dmaData(dmaData), .busDataOut(busDataOut));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
    endfunction
    // One I/O access; address and enables change after the strobe to prove latching
    task automatic io(input logic wr, input logic [15:2] a, input logic [3:0] be, input logic q,
        input logic [31:0] d);
        logic nws;
        @(posedge clk);
        ioAddress <= a;
        byte_lane_enable_n <= be;
        io_space_qualifier <= q;
        ioData <= d;
        address_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        // Decode follows the live address, so look while it is valid
        rdDec = local_decode_n;
        nws = no_wait_request_n;
        address_strobe_n <= 1'b1;
        repeat (2) @(posedge clk);
        ioAddress <= ~a;
        byte_lane_enable_n <= 4'hf;
        repeat (8) @(posedge clk);
        if (wr) write_strobe_n <= 1'b0;
        else read_strobe_n <= 1'b0;
        // Half burst clock strobe when no-wait was requested
        repeat (nws ? 16 : 8) @(posedge clk);
        rdOe = busDataOe_n;
        rdData = busDataOut;
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_dma;
        int i;
        u_wbs_dma_ctrl.burst(1'b1, 16, 1'b1);
        for (i = 0; i < 16; i++) mem[i] = u_wbs_dma_ctrl.pat(i);
        repeat (4) @(posedge clk);
        check({28'h0, packetPointer}, 32'h0, "pointer after wrap");
        u_wbs_dma_ctrl.burst(1'b0, 16, 1'b1);
        check(u_wbs_dma_ctrl.seen.size(), 32'h10, "read count");
        for (i = 0; i < 16; i++) check(u_wbs_dma_ctrl.seen[i], mem[i], "dma read");
        $display("Test dma done");
    endtask
    task automatic t_iowrite;
        io(1'b1, DA, `WBS_BE_LOW, 1'b0, 32'h1111_2222);
        check({28'h0, packetPointer}, 32'h0, "low word keeps pointer");
        io(1'b1, DA, `WBS_BE_DWORD, 1'b1, 32'hffff_ffff);
        io(1'b1, {BASE, 2'h1}, `WBS_BE_DWORD, 1'b0, 32'hffff_ffff);
        io(1'b1, DA, `WBS_BE_B2, 1'b0, 32'h0033_0000);
        mem[0] = {mem[0][31:24], 8'h33, 16'h2222};
        io(1'b0, DA, `WBS_BE_DWORD, 1'b0, 32'h0);
        check(rdData, mem[0], "merged word");
        check({31'h0, rdDec}, 32'h0, "decode hit");
        $display("Test io write done");
    endtask
    task automatic t_lanes;
        logic [3:0] pats [7];
        logic [3:0] p;
        int i;
        // Only supported enable patterns go toward the device
        pats = '{`WBS_BE_DWORD, `WBS_BE_LOW, `WBS_BE_HIGH, `WBS_BE_B0, `WBS_BE_B1, `WBS_BE_B2,
            `WBS_BE_B3};
        p = 4'h1;
        for (i = 0; i < 7; i++) begin
            io(1'b0, DA, pats[i], 1'b0, 32'h0);
            check({28'h0, rdOe}, {28'h0, pats[i]}, "read lanes");
            check(rdData & lanes(pats[i]), mem[p] & lanes(pats[i]), "read data");
            if (!pats[i][3]) p++;
            check({28'h0, packetPointer}, {28'h0, p}, "pointer step");
        end
        io(1'b0, DA, `WBS_BE_DWORD, 1'b1, 32'h0);
        check({31'h0, rdDec}, 32'h1, "qualifier high");
        io(1'b0, {12'h031, 2'h2}, `WBS_BE_DWORD, 1'b0, 32'h0);
        check({31'h0, rdDec}, 32'h1, "window miss");
        check({28'h0, rdOe}, 32'hf, "miss not driven");
        check({28'h0, packetPointer}, {28'h0, p}, "miss keeps pointer");
        $display("Test lanes done");
    endtask
    task automatic conclude;
        $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200us;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check({23'h0, busDataOe_n, local_decode_n, packetPointer}, {23'h0, 4'hf, 1'b1, 4'h0},
            "reset outputs");
        t_dma();
        t_iowrite();
        t_lanes();
        conclude();
    end
endmodule // tb_wbs_slave_port
